// >>> testbench/epsu_core_model.sv
// Behavioural core model: answers entry and restore sequences of the unit
module epsu_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Requests from the unit
  input  wire logic vector_fetch,
  input  wire logic stack_pop,
  // Pace select: slow answers after five cycles, prompt after one
  input  wire logic slow,
  // Completion pulses back to the unit
  output logic      entry_done,
  output logic      pop_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_reg;   // Cycles left before the answer
  logic       busy_e;    // Entry or tail-chain fetch in progress
  logic       busy_p;    // State restore in progress

  // One sequence at a time; a new request is not expected while busy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg    <= 3'h0;
      busy_e     <= 1'b0;
      busy_p     <= 1'b0;
      entry_done <= 1'b0;
      pop_done   <= 1'b0;
    end else begin
      entry_done <= 1'b0;
      pop_done   <= 1'b0;
      if (vector_fetch || stack_pop) begin
        // Latch the kind of work and its length
        busy_e  <= vector_fetch;
        busy_p  <= stack_pop;
        cnt_reg <= slow ? 3'h5 : 3'h1;
      end else if (busy_e || busy_p) begin
        if (cnt_reg == 3'h1) begin
          // Pulses last one cycle, as the unit honours them once
          entry_done <= busy_e;
          pop_done   <= busy_p;
          busy_e     <= 1'b0;
          busy_p     <= 1'b0;
        end
        cnt_reg <= cnt_reg - 3'h1;
      end
    end
  end
endmodule : epsu_core_model

// >>> testbench/epsu_top_tb.sv
// Self-checking bench for the exception priority unit
module epsu_top_tb;
  import epsu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, reg_wr, reg_rd, nmi_in, hf, exc_ret, slow;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [33:0] irq_in;
  logic        push, fetch, pop, hmode, e_done, p_done, irq_out;
  logic [5:0]  vnum;
  logic [31:0] pw [5];  // Mirror of the priority words
  int n_fail, check_count;

  epsu_top uut (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .irq_in(irq_in),
    .nmi_in(nmi_in), .hard_fault_req(hf), .stack_push(push), .vector_fetch(fetch),
    .vector_num(vnum), .stack_pop(pop), .handler_mode(hmode), .entry_done(e_done),
    .exc_return(exc_ret), .pop_done(p_done), .irq_out(irq_out));
  epsu_core_model core (.clk(clk), .rst_b(rst_b), .vector_fetch(fetch),
    .stack_pop(pop), .slow(slow), .entry_done(e_done), .pop_done(p_done));

  // 100 ns period clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // Register values
  task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  // Core-side outputs and irq_out
  task automatic chk_sig(string nm, logic [5:0] e, logic [5:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_sig

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Let the write settle before anyone looks at its effect
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    addr   <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk_reg(nm, e, d);
  endtask : rchk

  function automatic logic [5:0] ivec(int k);
    return VEC_IRQ0 + 6'(k);
  endfunction : ivec

  // Set one interrupt's priority through the mirror word
  task automatic sp(int k, logic [2:0] p);
    pw[k/8][(k%8)*4 +: 4] = {1'b0, p};
    wr(ADDR_IRQ_PRIO + 8'(4*(k/8)), pw[k/8]);
  endtask : sp

  // Wait for a fetch, check it, then let the core finish the entry
  task automatic expect_entry(logic [5:0] vec, logic exp_push);
    int i;
    for (i = 0; i < 40 && fetch !== 1'b1; i++) @(posedge clk) #1;
    if (i == 40) n_fail++;
    chk_sig("push", 6'(exp_push), 6'(push));
    chk_sig("vector", vec, vnum);
    chk_sig("no_pop", 6'h0, 6'(pop));
    for (i = 0; i < 40 && e_done !== 1'b1; i++) @(posedge clk) #1;
    if (i == 40) n_fail++;
    @(posedge clk);
  endtask : expect_entry

  // Finish the running handler: restore, or chain to the next one
  task automatic do_return(logic tail, logic [5:0] vec);
    int i;
    slow <= 1'($urandom);
    @(posedge clk);
    exc_ret <= 1'b1;
    @(posedge clk);
    exc_ret <= 1'b0;
    // The strobes rise at this very edge and stand one cycle only
    #1;
    for (i = 0; i < 40 && fetch !== 1'b1 && pop !== 1'b1; i++) @(posedge clk) #1;
    if (i == 40) n_fail++;
    chk_sig("pop", 6'(!tail), 6'(pop));
    chk_sig("push", 6'h0, 6'(push));
    if (tail) expect_entry(vec, 1'b0);
    else begin
      for (i = 0; i < 40 && p_done !== 1'b1; i++) @(posedge clk) #1;
      if (i == 40) n_fail++;
      @(posedge clk) #1;
    end
  endtask : do_return

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    {reg_wr, reg_rd, nmi_in, hf, exc_ret, slow} = 6'h00;
    {rst_b, addr, wdata, irq_in} = '0;
    n_fail = 0;
    check_count = 0;
    void'($urandom(36999));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // Reset priorities, then random priority fields
    rchk("sys_prio", ADDR_SYS_PRIO, 32'h0000_0000);
    for (int w = 0; w < 5; w++) begin
      rchk("irq_prio", ADDR_IRQ_PRIO + 8'(4*w), 32'h0000_0000);
      v = $urandom & 32'h7777_7777;
      wr(ADDR_IRQ_PRIO + 8'(4*w), v);
      // The last word holds only the two top interrupts
      rchk("irq_prio", ADDR_IRQ_PRIO + 8'(4*w), w == 4 ? v & 32'h0000_0077 : v);
      pw[w] = 32'h7777_7777;
      wr(ADDR_IRQ_PRIO + 8'(4*w), pw[w]);
    end
    // Random set and clear of the enables; unmapped offset reads 0
    v = $urandom;
    wr(ADDR_EN_SET0, v);
    wr(ADDR_EN_SET1, v);
    rchk("en0", ADDR_EN_SET0, v);
    rchk("en1", ADDR_EN_SET1, v & 32'h0000_0003);
    wr(ADDR_EN_CLR0, v);
    wr(ADDR_EN_CLR1, v);
    rchk("en0", ADDR_EN_CLR0, 32'h0000_0000);
    rchk("unmapped", 8'hFC, 32'h0000_0000);
    wr(ADDR_INT_MASK, 32'h0000_0001);
    // Software pend while disabled, then enable and take it
    sp(3, 3'h2);
    sp(5, 3'h1);
    sp(7, 3'h2);
    wr(ADDR_PEND0, 32'h0000_0008);
    rchk("pend", ADDR_PEND0, 32'h0000_0008);
    rchk("act", ADDR_ACT0, 32'h0000_0000);
    wr(ADDR_EN_SET0, 32'h0000_00A8);
    expect_entry(ivec(3), 1'b1);
    chk_sig("hmode", 6'h1, 6'(hmode));
    rchk("act", ADDR_ACT0, 32'h0000_0008);
    rchk("pend", ADDR_PEND0, 32'h0000_0000);
    chk_sig("irq_out", 6'h1, 6'(irq_out));
    wr(ADDR_INT_STAT, 32'h0000_0001);
    chk_sig("irq_out", 6'h0, 6'(irq_out));
    // Equal preemption level waits; a more urgent one preempts
    wr(ADDR_PEND0, 32'h0000_0080);
    rchk("act", ADDR_ACT0, 32'h0000_0008);
    wr(ADDR_PEND0, 32'h0000_0020);
    expect_entry(ivec(5), 1'b1);
    rchk("act", ADDR_ACT0, 32'h0000_0028);
    wr(ADDR_PEND0, 32'h0000_0020);
    rchk("pend", ADDR_PEND0, 32'h0000_00A0);
    do_return(1'b1, ivec(5));
    do_return(1'b0, 6'h00);
    do_return(1'b1, ivec(7));
    do_return(1'b0, 6'h00);
    chk_sig("hmode", 6'h0, 6'(hmode));
    // Fixed ranks above the most urgent programmable level
    sp(3, 3'h0);
    wr(ADDR_PEND0, 32'h0000_0008);
    expect_entry(ivec(3), 1'b1);
    @(posedge clk);
    hf <= 1'b1;
    @(posedge clk);
    hf <= 1'b0;
    expect_entry(VEC_HF, 1'b1);
    nmi_in <= 1'b1;
    expect_entry(VEC_NMI, 1'b1);
    rchk("act_sys", ADDR_ACT_SYS, 32'h0000_0003);
    nmi_in <= 1'b0;
    for (int i = 0; i < 3; i++) do_return(1'b0, 6'h00);
    // One subpriority bit: ties by subpriority, then lowest number
    wr(ADDR_CTRL, 32'h0000_0001);
    sp(10, 3'h2);
    sp(11, 3'h2);
    sp(4, 3'h3);
    wr(ADDR_PEND0, 32'h0000_0C10);
    wr(ADDR_EN_SET0, 32'h0000_0C10);
    expect_entry(ivec(10), 1'b1);
    rchk("act", ADDR_ACT0, 32'h0000_0400);
    do_return(1'b1, ivec(11));
    do_return(1'b1, ivec(4));
    do_return(1'b0, 6'h00);
    // Line request; the source is cleared early in its handler
    sp(0, 3'h1);
    wr(ADDR_EN_SET0, 32'h0000_0001);
    irq_in[0] <= 1'b1;
    expect_entry(ivec(0), 1'b1);
    irq_in[0] <= 1'b0;
    rchk("pend", ADDR_PEND0, 32'h0000_0001);
    do_return(1'b1, ivec(0));
    do_return(1'b0, 6'h00);
    rchk("pend", ADDR_PEND0, 32'h0000_0000);
    // Status flags, mask and clear
    rchk("int_stat", ADDR_INT_STAT, 32'h0000_0007);
    chk_sig("irq_out", 6'h1, 6'(irq_out));
    wr(ADDR_INT_MASK, 32'h0000_0000);
    chk_sig("irq_out", 6'h0, 6'(irq_out));
    wr(ADDR_INT_STAT, 32'h0000_0007);
    rchk("int_stat", ADDR_INT_STAT, 32'h0000_0000);
    report_and_stop();
  end
endmodule : epsu_top_tb

// >>> verilog/epsu_pkg.sv
// Constants, register map and state type of the exception priority unit
package epsu_pkg;
  // Source layout: NMI, hard fault, seven system handlers, then interrupts
  localparam int NUM_IRQ_DEF = 34;
  localparam int NUM_SYS     = 7;
  localparam int IDX_NMI     = 0;
  localparam int IDX_HF      = 1;
  localparam int IDX_SYS0    = 2;
  localparam int IDX_IRQ0    = 9;
  localparam int PRIO_W      = 3;
  localparam int IDX_W       = 6;
  localparam int VEC_W       = 6;
  localparam int RANK_W      = 4;
  localparam int INT_W       = 3;
  // Ranks: lower is more urgent; programmable values sit after NMI and HF
  localparam logic [3:0] RANK_NMI      = 4'h0;
  localparam logic [3:0] RANK_HF       = 4'h1;
  localparam logic [3:0] RANK_PROG_OFS = 4'h2;
  localparam logic [3:0] RANK_IDLE     = 4'hF;
  // Vector numbers
  localparam logic [5:0]  VEC_NMI       = 6'h02;
  localparam logic [5:0]  VEC_HF        = 6'h03;
  localparam logic [5:0]  VEC_IRQ0      = 6'h10;
  localparam logic [41:0] SYS_VEC_TABLE = {6'h0F, 6'h0E, 6'h0C, 6'h0B, 6'h06, 6'h05, 6'h04};
  // Register offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_EN_SET0  = 8'h04;
  localparam logic [7:0] ADDR_EN_SET1  = 8'h08;
  localparam logic [7:0] ADDR_EN_CLR0  = 8'h0C;
  localparam logic [7:0] ADDR_EN_CLR1  = 8'h10;
  localparam logic [7:0] ADDR_PEND0    = 8'h14;
  localparam logic [7:0] ADDR_PEND1    = 8'h18;
  localparam logic [7:0] ADDR_SYS_PEND = 8'h1C;
  localparam logic [7:0] ADDR_ACT0     = 8'h20;
  localparam logic [7:0] ADDR_ACT1     = 8'h24;
  localparam logic [7:0] ADDR_ACT_SYS  = 8'h28;
  localparam logic [7:0] ADDR_STATE    = 8'h2C;
  localparam logic [7:0] ADDR_INT_STAT = 8'h30;
  localparam logic [7:0] ADDR_INT_MASK = 8'h34;
  localparam logic [7:0] ADDR_SYS_PRIO = 8'h40;
  localparam logic [7:0] ADDR_IRQ_PRIO = 8'h50;
  // Reset values and field positions
  localparam logic [1:0]  GROUP_RST = 2'h0;
  localparam logic [2:0]  PRIO_RST  = 3'h0;
  localparam logic [2:0]  MASK_RST  = 3'h0;
  localparam int          FLD_PRIO  = 4;
  localparam int          FLD_STATE = 8;
  localparam int          INT_TAKE  = 0;
  localparam int          INT_TAIL  = 1;
  localparam int          INT_THRD  = 2;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_THREAD  = 2'b00,
    ST_ENTRY   = 2'b01,
    ST_HANDLER = 2'b10,
    ST_POP     = 2'b11
  } epsu_state_e;
endpackage : epsu_pkg

// >>> verilog/epsu_top.sv
// Exception prioritisation, state tracking and entry/return sequencer
// How it works
// RQ1 - Enter handler mode, push and pop state
// RQ2 - Vector fetch issued with the stack push
// RQ3 - Tail-chain: no pop, no second push
// RQ4 - Eight levels, seven handlers, 34 interrupts
// RQ5 - Set-enable bits and priority fields held
// RQ6 - Group split; only preempt part preempts
// RQ7 - Priority zero ranks after reset, NMI, fault
// RQ8 - All priority fields reset to zero
// RQ9 - Software clears sources early in handler
// RQ10 - Neither active nor pending means inactive
// RQ11 - Line or software request sets pending
// RQ12 - Active from handler start to completion
// RQ13 - Nested handlers all stay active
// RQ14 - New request while active gives both flags
// RQ15 - NMI fixed at minus two, always enabled
// RQ16 - Hard fault fixed at minus one
// RQ17 - Preempt only strictly more urgent; take flags
// RQ18 - Ties broken by subpriority, then number
module epsu_top #(
  parameter int NUM_IRQ = epsu_pkg::NUM_IRQ_DEF
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // Register port
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  // Request sources
  input  wire logic [NUM_IRQ-1:0]         irq_in,
  input  wire logic                       nmi_in,
  input  wire logic                       hard_fault_req,
  // Core sequencing
  output logic                            stack_push,
  output logic                            vector_fetch,
  output logic      [epsu_pkg::VEC_W-1:0] vector_num,
  output logic                            stack_pop,
  output logic                            handler_mode,
  input  wire logic                       entry_done,
  input  wire logic                       exc_return,
  input  wire logic                       pop_done,
  // Interrupt to system
  output logic                            irq_out
);
  import epsu_pkg::*;

  localparam int NUM_SRC  = NUM_IRQ + IDX_IRQ0;
  localparam int NUM_PRIO = NUM_SRC - IDX_SYS0;

  logic [NUM_IRQ-1:0]     irq_meta_reg;        // First sync stage
  logic [NUM_IRQ-1:0]     irq_sync_reg;        // Second sync stage
  logic                   nmi_meta_reg;        // First sync stage
  logic                   nmi_sync_reg;        // Second sync stage
  logic                   nmi_last_reg;        // Edge history
  logic [1:0]             group_reg;           // Subpriority bit count
  logic [NUM_IRQ-1:0]     en_reg;              // Interrupt enables
  logic [PRIO_W-1:0]      prio_reg [NUM_PRIO]; // Programmable priorities
  logic [NUM_SRC-1:0]     pend_reg;            // Pending flags
  logic [NUM_SRC-1:0]     act_reg;             // Active flags
  epsu_state_e            st_reg;              // Sequencer state
  logic [INT_W-1:0]       int_stat_reg;        // Sticky events
  logic [INT_W-1:0]       int_mask_reg;        // Event mask
  logic                   wr_seen_reg;         // Any write since reset
  logic [NUM_SRC-1:0]     en_src;              // Enable per source
  logic [NUM_SRC-1:0]     sw_pend;             // Software pend requests
  logic                   win_valid;           // A pending candidate exists
  logic [IDX_W-1:0]       win_idx;             // Best pending source
  logic [RANK_W-1:0]      win_rank;            // Its preemption rank
  logic [RANK_W-1:0]      cur_rank;            // Running preemption rank
  logic [RANK_W-1:0]      rest_rank;           // Rank once returning one ends
  logic [IDX_W-1:0]       ret_idx;             // Handler now running
  logic                   act_any;             // Any handler active
  logic                   ret_now;             // Return requested
  logic                   tail_now;            // Chain into next handler
  logic                   pop_now;             // Unstack on return
  logic                   take_now;            // Preempting entry
  logic                   entry_now;           // Any vector fetch
  logic [31:0]            rd_word;             // Read mux

  // Priority of a source; NMI and hard fault carry none
  function automatic logic [PRIO_W-1:0] prio_of(input int idx);
    if (idx < IDX_SYS0) begin
      return PRIO_RST;
    end
    return prio_reg[idx-IDX_SYS0];
  endfunction : prio_of

  // Preemption rank: fixed levels first, then masked value
  function automatic logic [RANK_W-1:0] rank_of(input int idx);
    logic [PRIO_W-1:0] pre_mask;
    pre_mask = 3'h7 << group_reg; // RQ6
    if (idx == IDX_NMI) begin
      return RANK_NMI; // RQ15
    end
    if (idx == IDX_HF) begin
      return RANK_HF; // RQ16
    end
    return {1'b0, prio_of(idx) & pre_mask} + RANK_PROG_OFS; // RQ7
  endfunction : rank_of

  // Full ordering key: rank, subpriority, then number
  function automatic logic [12:0] key_of(input int idx);
    logic [PRIO_W-1:0] sub_mask;
    sub_mask = ~(3'h7 << group_reg);
    return {rank_of(idx), prio_of(idx) & sub_mask, 6'(idx)}; // RQ18
  endfunction : key_of

  // Vector number of a source
  function automatic logic [VEC_W-1:0] vec_of(input logic [IDX_W-1:0] idx);
    if (idx == 6'(IDX_NMI)) begin
      return VEC_NMI;
    end
    if (idx == 6'(IDX_HF)) begin
      return VEC_HF;
    end
    if (idx < 6'(IDX_IRQ0)) begin
      return SYS_VEC_TABLE[6*(int'(idx)-IDX_SYS0) +: 6];
    end
    return VEC_IRQ0 + idx - 6'(IDX_IRQ0);
  endfunction : vec_of

  // Pin synchronisers; only stage two feeds logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_meta_reg <= '0;
      irq_sync_reg <= '0;
      nmi_meta_reg <= 1'b0;
      nmi_sync_reg <= 1'b0;
      nmi_last_reg <= 1'b0;
    end else begin
      irq_meta_reg <= irq_in;
      irq_sync_reg <= irq_meta_reg;
      nmi_meta_reg <= nmi_in;
      nmi_sync_reg <= nmi_meta_reg;
      nmi_last_reg <= nmi_sync_reg;
    end
  end

  // NMI, hard fault and system handlers cannot be disabled here
  assign en_src = {en_reg, {IDX_IRQ0{1'b1}}}; // RQ15

  // Software pend requests from register writes
  always_comb begin
    sw_pend = '0;
    for (int k = 0; k < NUM_IRQ; k++) begin
      if (reg_wr && reg_addr == (k < 32 ? ADDR_PEND0 : ADDR_PEND1)) begin
        sw_pend[IDX_IRQ0+k] = reg_wdata[k%32]; // RQ11
      end
    end
    // Only the seven system handlers; bit 7 belongs to NMI, not to line 0
    for (int k = 0; k < NUM_SYS; k++) begin
      if (reg_wr && reg_addr == ADDR_SYS_PEND) begin
        sw_pend[IDX_SYS0+k] = reg_wdata[k];
      end
    end
    if (reg_wr && reg_addr == ADDR_SYS_PEND) begin
      sw_pend[IDX_NMI] = reg_wdata[IDX_IRQ0-IDX_SYS0];
    end
  end

  // Winner among pending, running level and returning handler
  always_comb begin
    logic [12:0] best;
    logic [12:0] abest;
    best      = '1;
    abest     = '1;
    win_valid = 1'b0;
    act_any   = 1'b0;
    rest_rank = RANK_IDLE;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pend_reg[i] && en_src[i] && key_of(i) < best) begin // RQ5
        best      = key_of(i);
        win_valid = 1'b1;
      end
      if (act_reg[i] && key_of(i) < abest) begin // RQ13
        abest   = key_of(i);
        act_any = 1'b1;
      end
    end
    win_idx  = best[5:0];
    win_rank = best[12:9];
    ret_idx  = abest[5:0];
    cur_rank = act_any ? abest[12:9] : RANK_IDLE;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (act_reg[i] && 6'(i) != ret_idx && rank_of(i) < rest_rank) begin
        rest_rank = rank_of(i);
      end
    end
  end

  // Sequencer decisions; a return outranks a preemption in one cycle
  assign ret_now   = (st_reg == ST_HANDLER) && exc_return;
  assign tail_now  = ret_now && win_valid && (win_rank < rest_rank); // RQ3
  assign pop_now   = ret_now && !tail_now;
  assign take_now  = (st_reg == ST_THREAD || (st_reg == ST_HANDLER && !exc_return))
                     && win_valid && (win_rank < cur_rank); // RQ17
  assign entry_now = take_now || tail_now;

  // Sequencer state and core strobes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg       <= ST_THREAD;
      stack_push   <= 1'b0;
      vector_fetch <= 1'b0;
      vector_num   <= '0;
      stack_pop    <= 1'b0;
      handler_mode <= 1'b0;
    end else begin
      stack_push   <= take_now;  // RQ1
      vector_fetch <= entry_now; // RQ2
      stack_pop    <= pop_now;   // RQ1
      if (entry_now) begin
        vector_num   <= vec_of(win_idx);
        handler_mode <= 1'b1; // RQ1
      end
      case (st_reg)
        ST_THREAD, ST_HANDLER: begin
          if (entry_now) begin
            st_reg <= ST_ENTRY;
          end else if (pop_now) begin
            st_reg <= ST_POP;
          end
        end
        ST_ENTRY: begin
          // Late arrivals wait until the handler is under way
          if (entry_done) begin
            st_reg <= ST_HANDLER;
          end
        end
        ST_POP: begin
          if (pop_done) begin
            st_reg       <= act_any ? ST_HANDLER : ST_THREAD;
            handler_mode <= act_any;
          end
        end
        default: begin
          st_reg <= ST_THREAD;
        end
      endcase
    end
  end

  // Pending and active flags; a new request beats the take clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= '0;
      act_reg  <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        logic set_p;
        set_p = sw_pend[i];
        if (i >= IDX_IRQ0) begin
          set_p = set_p || irq_sync_reg[i-IDX_IRQ0]; // RQ11
        end
        if (i == IDX_NMI) begin
          set_p = set_p || (nmi_sync_reg && !nmi_last_reg);
        end
        if (i == IDX_HF) begin
          set_p = set_p || hard_fault_req;
        end
        // Level lines re-pend at once, so sources must drop early
        if (entry_now && win_idx == 6'(i)) begin // RQ9
          pend_reg[i] <= set_p;     // RQ17
          act_reg[i]  <= 1'b1;      // RQ12
        end else begin
          pend_reg[i] <= pend_reg[i] || set_p; // RQ14
          if (ret_now && ret_idx == 6'(i)) begin
            act_reg[i] <= 1'b0;     // RQ10
          end
        end
      end
    end
  end

  // Configuration writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      group_reg    <= GROUP_RST;
      en_reg       <= '0;
      int_mask_reg <= MASK_RST;
      wr_seen_reg  <= 1'b0;
      for (int p = 0; p < NUM_PRIO; p++) begin
        prio_reg[p] <= PRIO_RST; // RQ8
      end
    end else if (reg_wr) begin
      wr_seen_reg <= 1'b1;
      if (reg_addr == ADDR_CTRL) begin
        group_reg <= reg_wdata[1:0]; // RQ6
      end
      if (reg_addr == ADDR_INT_MASK) begin
        int_mask_reg <= reg_wdata[INT_W-1:0];
      end
      for (int k = 0; k < NUM_IRQ; k++) begin
        if (reg_addr == (k < 32 ? ADDR_EN_SET0 : ADDR_EN_SET1) && reg_wdata[k%32]) begin
          en_reg[k] <= 1'b1; // RQ5
        end
        if (reg_addr == (k < 32 ? ADDR_EN_CLR0 : ADDR_EN_CLR1) && reg_wdata[k%32]) begin
          en_reg[k] <= 1'b0;
        end
        if (reg_addr == 8'(ADDR_IRQ_PRIO + 4*(k/8))) begin
          prio_reg[NUM_SYS+k] <= reg_wdata[FLD_PRIO*(k%8) +: PRIO_W]; // RQ4
        end
      end
      for (int s = 0; s < NUM_SYS; s++) begin
        if (reg_addr == ADDR_SYS_PRIO) begin
          prio_reg[s] <= reg_wdata[FLD_PRIO*s +: PRIO_W]; // RQ4
        end
      end
    end
  end

  // Sticky events, write one to clear; a new event wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~((reg_wr && reg_addr == ADDR_INT_STAT)
                       ? reg_wdata[INT_W-1:0] : 3'h0))
                      | {(st_reg == ST_POP) && pop_done && !act_any, tail_now, take_now};
    end
  end

  assign irq_out = |(int_stat_reg & int_mask_reg);

  // Read mux; unmapped offsets return zero
  always_comb begin
    logic [63:0] en_w;
    logic [63:0] pd_w;
    logic [63:0] ac_w;
    en_w    = 64'(en_reg);
    pd_w    = 64'(pend_reg[NUM_SRC-1:IDX_IRQ0]);
    ac_w    = 64'(act_reg[NUM_SRC-1:IDX_IRQ0]);
    rd_word = '0;
    case (reg_addr)
      ADDR_CTRL:                  rd_word = 32'(group_reg);
      ADDR_EN_SET0, ADDR_EN_CLR0: rd_word = en_w[31:0];
      ADDR_EN_SET1, ADDR_EN_CLR1: rd_word = en_w[63:32];
      ADDR_PEND0:                 rd_word = pd_w[31:0];
      ADDR_PEND1:                 rd_word = pd_w[63:32];
      ADDR_SYS_PEND:              rd_word = 32'({pend_reg[IDX_NMI], pend_reg[IDX_IRQ0-1:IDX_SYS0]});
      ADDR_ACT0:                  rd_word = ac_w[31:0];
      ADDR_ACT1:                  rd_word = ac_w[63:32];
      ADDR_ACT_SYS:               rd_word = 32'(act_reg[IDX_IRQ0-1:0]);
      ADDR_STATE:                 rd_word = 32'({st_reg, 2'h0, act_any ? vec_of(ret_idx) : 6'h00});
      ADDR_INT_STAT:              rd_word = 32'(int_stat_reg);
      ADDR_INT_MASK:              rd_word = 32'(int_mask_reg);
      ADDR_SYS_PRIO: begin
        for (int s = 0; s < NUM_SYS; s++) begin
          rd_word[FLD_PRIO*s +: PRIO_W] = prio_reg[s];
        end
      end
      default: begin
        for (int k = 0; k < NUM_IRQ; k++) begin
          if (reg_addr == 8'(ADDR_IRQ_PRIO + 4*(k/8))) begin
            rd_word[FLD_PRIO*(k%8) +: PRIO_W] = prio_reg[NUM_SYS+k];
          end
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_word : 32'h0000_0000;
    end
  end

  // Checks
  sequence seq_return;
    st_reg == ST_HANDLER && exc_return;
  endsequence

  sequence seq_chain;
    seq_return ##0 win_valid && win_rank < rest_rank;
  endsequence

  AST_PUSH_WITH_FETCH: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
    stack_push |-> vector_fetch && handler_mode && st_reg == ST_ENTRY)
    else $error("push without vector fetch");
  AST_CHAIN_NO_UNSTACK: assert property (@(posedge clk) disable iff (!rst_b) // RQ3
    seq_chain |=> vector_fetch && !stack_push && !stack_pop)
    else $error("tail chain restacked");
  AST_POP_ON_RETURN: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
    stack_pop |-> $past(exc_return) && $past(st_reg) == ST_HANDLER && st_reg == ST_POP)
    else $error("pop without return");
  AST_NMI_FIRST: assert property (@(posedge clk) disable iff (!rst_b) // RQ15
    pend_reg[IDX_NMI] |-> win_valid && win_idx == 6'(IDX_NMI))
    else $error("pending NMI not chosen");
  AST_FAULT_SECOND: assert property (@(posedge clk) disable iff (!rst_b) // RQ16
    pend_reg[IDX_HF] && !pend_reg[IDX_NMI] |-> win_idx == 6'(IDX_HF))
    else $error("pending fault not chosen");
  AST_PRIO_RESET_ZERO: assert property (@(posedge clk) disable iff (!rst_b) // RQ8
    !wr_seen_reg |-> prio_reg[0] == 3'h0 && prio_reg[NUM_PRIO-1] == 3'h0)
    else $error("priority not zero after reset");
  AST_TAKE_ACTIVE: assert property (@(posedge clk) disable iff (!rst_b) // RQ12
    vector_fetch |-> act_reg[vector_num >= VEC_IRQ0 ? vector_num - VEC_IRQ0 + 6'(IDX_IRQ0)
                     : 6'(IDX_NMI)] || vector_num < VEC_IRQ0)
    else $error("taken source not active");
  AST_STRICT_PREEMPT: assert property (@(posedge clk) disable iff (!rst_b) // RQ17
    stack_push && $past(st_reg) == ST_HANDLER |-> $past(win_rank) < $past(cur_rank))
    else $error("preempted by equal or lower rank");
  AST_ACTIVE_PEND: assert property (@(posedge clk) disable iff (!rst_b) // RQ14
    irq_sync_reg[0] && act_reg[IDX_IRQ0] |=> pend_reg[IDX_IRQ0])
    else $error("request lost while active");
  AST_THREAD_IDLE: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
    st_reg == ST_THREAD |-> act_reg == '0 && !handler_mode)
    else $error("thread with active handler");
endmodule : epsu_top
